// ---- design/seq_pkg.sv ----
package seq_pkg;
  localparam int          NUM_STEPS   = 16;
  localparam int          STEP_W      = 4;
  localparam int          FREQ_W      = 16;   // step frequency in 0.01 hz units
  localparam int          TIME_W      = 12;   // run time in seconds
  localparam int          MODE_W      = 3;
  localparam int          CLK_HZ      = 50000000;
  localparam int          TICK_S      = 1;    // time base in seconds
  localparam int          TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 16'h9c40; // 400.00 hz
  localparam logic [TIME_W-1:0] TIME_MAX = 12'he10;  // 3600 s
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
  localparam logic [MODE_W-1:0] MODE_MAX = 3'h6;
  localparam logic [1:0]  DIR_STOP    = 2'h0;
  localparam logic [1:0]  DIR_FWD     = 2'h1;
  localparam logic [1:0]  DIR_REV     = 2'h2;

  typedef struct packed {
    logic              active;  // sequencer owns the drive commands
    logic [1:0]        dir;     // stop / forward / reverse
    logic [FREQ_W-1:0] freq;    // target frequency
  } drive_cmd_t;
endpackage

// ---- design/second_tick.sv ----
`timescale 1ns/1ps
// one-cycle pulse once per second while counting is allowed
module second_tick #(
  parameter int CYCLES = seq_pkg::TICK_CYCLES
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic rstn,     // async reset, active low
  input  wire logic run,      // count while high, else restart
  output logic      tick      // one-cycle pulse
);
  import seq_pkg::*;
  logic [31:0] cnt_reg;

  // divider restarts whenever counting stops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule

// ---- design/auto_run_step_sequencer.sv ----
// Notes on behaviour
// RULE1: mode 0 off; 1,4 single cycle; 2,5 periodic; 3,6 single then hold.
// RULE2: periodic modes wrap from last step back to step 0 forever.
// RULE3: hold modes keep the final step's command after the cycle ends.
// RULE4: modes 1-3 resume the unfinished step after stop and rerun.
// RULE5: modes 4-6 restart a fresh cycle after stop and rerun.
// RULE6: fifteen step frequencies, steps 1 to 15, each 0 to 400 hz.
// RULE7: each step 0 to 15 has its own run time, 0 to 3600 s.
// RULE8: each step has direction: 0 stop, 1 forward, 2 reverse.
// RULE9: operator assigns terminal function 22 and closes that terminal.
// RULE10: each step's duration is counted on its own before advancing.
// RULE11: step 0 frequency is the keypad panel frequency.
// RULE12: single-cycle modes without hold stop the motor at cycle end.
// RULE13: advance when per-second step counter reaches configured time.
// RULE14: disabled or terminal open means no commands; normal sources rule.
`timescale 1ns/1ps
module auto_run_step_sequencer #(
  parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES,
  parameter int LAST_STEP   = seq_pkg::NUM_STEPS - 1
) (
  input  wire logic                                   sys_clk,    // system clock
  input  wire logic                                   rstn,       // async reset, active low
  input  wire logic [seq_pkg::MODE_W-1:0]             mode,       // sequencer mode
  input  wire logic                                   enable_in,  // auto-run terminal pin
  input  wire logic                                   run_in,     // run command, same clock
  input  wire logic [seq_pkg::FREQ_W-1:0]             panel_freq, // keypad frequency
  input  wire logic [seq_pkg::NUM_STEPS*seq_pkg::FREQ_W-1:0] step_freq, // step freqs
  input  wire logic [seq_pkg::NUM_STEPS*seq_pkg::TIME_W-1:0] step_time, // step times
  input  wire logic [seq_pkg::NUM_STEPS*2-1:0]        step_dir,   // step directions
  output seq_pkg::drive_cmd_t                         cmd,        // drive command
  output logic [seq_pkg::STEP_W-1:0]                  step_out,   // current step
  output logic                                        done        // cycle finished
);
  import seq_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_STEP, S_END} state_t;

  // sequence position and timing
  state_t                state_reg;
  logic   [STEP_W-1:0]   step_reg;
  logic   [TIME_W-1:0]   elapsed_reg;
  // terminal synchroniser, run edge and seconds pulse
  logic                  en_meta_reg;
  logic                  en_sync_reg;
  logic                  run_q_reg;
  logic                  tick;
  // decoded mode and run conditions
  logic                  valid_mode;
  logic                  periodic;
  logic                  hold;
  logic                  fresh;
  logic                  go;
  logic                  run_rise;
  logic                  running;
  logic                  restart;
  logic                  advance;
  // per-step settings after clamping
  logic   [FREQ_W-1:0]   freq_tab [NUM_STEPS];
  logic   [TIME_W-1:0]   time_tab [NUM_STEPS];
  logic   [1:0]          dir_tab  [NUM_STEPS];
  logic                  step_over;
  logic                  last;
  drive_cmd_t            cmd_next;

  // terminal pin passes two flip-flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= enable_in; // RULE9
      en_sync_reg <= en_meta_reg;
    end
  end

  // mode decode
  assign valid_mode = (mode != MODE_OFF) && (mode <= MODE_MAX);   // RULE1
  assign periodic   = (mode == 3'h2) || (mode == 3'h5);           // RULE1
  assign hold       = (mode == 3'h3) || (mode == 3'h6);           // RULE1
  assign fresh      = (mode >= 3'h4);                             // RULE5
  assign go         = valid_mode && en_sync_reg && run_in;        // RULE14
  assign run_rise   = go && !run_q_reg;

  // unpack the per-step settings, clamped to their legal ranges
  for (genvar i = 0; i < NUM_STEPS; i++) begin : g_tab
    logic [FREQ_W-1:0] f;
    logic [TIME_W-1:0] t;
    assign f = (i == 0) ? panel_freq : step_freq[i*FREQ_W +: FREQ_W]; // RULE11 RULE6
    assign t = step_time[i*TIME_W +: TIME_W];
    assign freq_tab[i] = (f > FREQ_MAX) ? FREQ_MAX : f;               // RULE6
    assign time_tab[i] = (t > TIME_MAX) ? TIME_MAX : t;               // RULE7
    assign dir_tab[i]  = (step_dir[i*2 +: 2] > DIR_REV) ? DIR_STOP
                                                        : step_dir[i*2 +: 2]; // RULE8
  end

  second_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (running),
    .tick    (tick)
  );

  // step finishes when its own counter reaches its own time
  assign step_over = (elapsed_reg >= time_tab[step_reg]) ||
                     (tick && (elapsed_reg + 12'h1 >= time_tab[step_reg])); // RULE13 RULE10
  assign last      = (step_reg == STEP_W'(LAST_STEP));

  // sequence live, a fresh start edge, and the end of the current step
  assign running   = go && (state_reg == S_STEP);
  assign restart   = run_rise && (fresh || state_reg == S_END); // RULE5
  assign advance   = running && step_over;                       // RULE13

  // run edge tracking
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_q_reg <= 1'b0;
    end else begin
      run_q_reg <= go;
    end
  end

  // sequence state: idle, stepping or cycle finished
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
    end else if (!valid_mode) begin
      state_reg <= S_IDLE; // RULE1
    end else if (run_rise) begin
      state_reg <= S_STEP; // RULE4 RULE5
    end else if (advance && last && !periodic) begin
      state_reg <= S_END; // RULE12 RULE3
    end
  end

  // step index: fresh start, advance, or wrap in periodic modes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      step_reg <= '0;
    end else if (!valid_mode) begin
      step_reg <= '0;
    end else if (restart) begin
      step_reg <= '0; // RULE5
    end else if (run_rise) begin
      step_reg <= step_reg; // RULE4
    end else if (advance && !last) begin
      step_reg <= step_reg + STEP_W'(1); // RULE10
    end else if (advance && periodic) begin
      step_reg <= '0; // RULE2
    end
  end

  // whole seconds spent in the current step; a resume keeps them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      elapsed_reg <= '0;
    end else if (!valid_mode) begin
      elapsed_reg <= '0;
    end else if (restart) begin
      elapsed_reg <= '0; // RULE5
    end else if (run_rise) begin
      elapsed_reg <= elapsed_reg; // RULE4
    end else if (advance) begin
      elapsed_reg <= '0; // RULE10
    end else if (running && tick) begin
      elapsed_reg <= elapsed_reg + TIME_W'(1); // RULE13
    end
  end

  // command selection per state; nothing while go is low
  always_comb begin
    cmd_next = '0;
    if (go) begin // RULE14
      unique case (state_reg)
        S_IDLE: begin
          cmd_next = '0;
        end
        S_STEP: begin
          cmd_next.active = 1'b1;
          cmd_next.dir    = dir_tab[step_reg];  // RULE8
          cmd_next.freq   = freq_tab[step_reg]; // RULE6 RULE11
        end
        S_END: begin
          cmd_next.active = 1'b1;
          if (hold) begin
            cmd_next.dir  = dir_tab[step_reg]; // RULE3
            cmd_next.freq = freq_tab[step_reg];
          end else begin
            cmd_next.dir  = DIR_STOP; // RULE12
            cmd_next.freq = '0;
          end
        end
        default: begin
          cmd_next = '0;
        end
      endcase
    end
  end

  // drive command register; inactive command releases control
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= '0;
    end else begin
      cmd <= cmd_next; // RULE14
    end
  end

  // current step index
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      step_out <= '0;
    end else begin
      step_out <= step_reg;
    end
  end

  // cycle finished flag
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
    end else begin
      done <= (state_reg == S_END); // RULE12
    end
  end
endmodule

// ---- tb/drive_ramp_model.sv ----
`timescale 1ns/1ps
// drive ramp stand-in, one unit a cycle
module drive_ramp_model (
  input  wire logic                sys_clk,   // clock
  input  wire logic                rstn,      // reset
  input  wire seq_pkg::drive_cmd_t cmd,       // sequencer command
  input  wire logic [15:0]         norm_freq, // normal source
  output logic [15:0]              speed      // ramp output
);
  logic [15:0] tgt;
  // sequencer owns target only while active
  assign tgt = cmd.active ? cmd.freq : norm_freq;
  // walk speed toward target
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) speed <= '0;
    else if (speed < tgt) speed <= speed + 16'h1;
    else if (speed > tgt) speed <= speed - 16'h1;
  end
endmodule

// ---- tb/seq_checker.sv ----
`timescale 1ns/1ps
module seq_checker
  import seq_pkg::*;
#(parameter int TICK_CYCLES = 2, parameter int LAST_STEP = 15) (
  input wire logic                sys_clk,   // clk
  input wire logic                rstn,      // reset
  input wire logic [2:0]          mode,      // mode
  input wire logic                enable_in, // pin
  input wire logic                run_in,    // run
  input wire logic [255:0]        step_freq, // freqs
  input wire logic [31:0]         step_dir,  // dirs
  input wire seq_pkg::drive_cmd_t cmd,       // command
  input wire logic [3:0]          step_out,  // step
  input wire logic                done       // finished
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // command ownership, codes, stepping and cycle end
  chk_off_clears: assert property ((mode == 3'h0)[*3] |-> cmd == '0 && !done)
    else $error("off");
  chk_open_idle: assert property (!enable_in[*6] |-> cmd == '0) else $error("pin open");
  chk_run_idle: assert property (!run_in[*3] |-> cmd == '0) else $error("run low");
  chk_dir_code: assert property (cmd.active |-> cmd.dir != 2'h3) else $error("dir");
  chk_freq_max: assert property (cmd.freq <= FREQ_MAX) else $error("freq");
  chk_step_order: assert property ($changed(step_out) |-> step_out == 4'h0 ||
    step_out == $past(step_out) + 4'h1) else $error("step order");
  chk_end_stop: assert property (done && $past(done) && (mode == 3'h1 || mode == 3'h4)
    && cmd.active |-> cmd.dir == DIR_STOP && cmd.freq == '0) else $error("end stop");
  chk_end_hold: assert property (done && $past(done) && (mode == 3'h3 || mode == 3'h6)
    && cmd.active |-> {cmd.dir, cmd.freq} == {step_dir[31:30], step_freq[255:240]})
    else $error("hold");
  chk_cyc_repeat: assert property ((mode == 3'h2 || mode == 3'h5)[*3] |-> !done)
    else $error("ended");
endmodule
bind auto_run_step_sequencer seq_checker #(.TICK_CYCLES(TICK_CYCLES), .LAST_STEP(LAST_STEP))
  i_seq_checker (.sys_clk(sys_clk), .rstn(rstn), .mode(mode), .enable_in(enable_in),
  .run_in(run_in), .step_freq(step_freq), .step_dir(step_dir), .cmd(cmd), .step_out(step_out),
  .done(done));

// ---- tb/auto_run_step_sequencer_tb_top.sv ----
`timescale 1ns/1ps
module auto_run_step_sequencer_tb_top;
  import seq_pkg::*;
  logic         sys_clk, rstn, enable_in, run_in, done;
  logic [2:0]   mode;
  logic [15:0]  panel_freq, speed;
  logic [255:0] step_freq;
  logic [191:0] step_time;
  logic [31:0]  step_dir;
  logic [3:0]   step_out, last_step;
  drive_cmd_t   cmd;
  int           errors, comparisons, cycles;
  logic [3:0]   exp_q[$];
  auto_run_step_sequencer #(.TICK_CYCLES(2)) i_auto_run_step_sequencer (.sys_clk(sys_clk),
    .rstn(rstn), .mode(mode), .enable_in(enable_in), .run_in(run_in), .panel_freq(panel_freq),
    .step_freq(step_freq), .step_time(step_time), .step_dir(step_dir), .cmd(cmd),
    .step_out(step_out), .done(done));
  drive_ramp_model i_drive_ramp_model (.sys_clk(sys_clk), .rstn(rstn), .cmd(cmd),
    .norm_freq(panel_freq), .speed(speed));
  // clock
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, and each step change takes the oldest note
  always @(posedge sys_clk) begin
    cycles++;
    last_step <= step_out;
    if (mode != 3'h0 && step_out !== last_step && exp_q.size() > 0)
      chk(step_out, exp_q.pop_front());
    if (cycles == 5000) begin
      errors++;
      report_and_stop;
    end
  end
  // one pass per mode: start, interrupt at step 3, finish or wrap, open pin
  initial begin
    {rstn, enable_in, run_in, mode, panel_freq, step_freq, step_time, step_dir} = '0;
    void'($urandom(23));
    cyc(8);
    rstn = 1;
    for (int m = 1; m <= 6; m++) begin
      panel_freq = 16'($urandom_range(40000));
      for (int i = 0; i < 16; i++) begin
        step_freq[i*16+:16] = 16'($urandom_range(40000));
        step_time[i*12+:12] = 12'($urandom_range(2));
        step_dir[i*2+:2] = 2'($urandom_range(2));
      end
      step_time[11:0] = 12'h3;
      step_time[47:36] = 12'h3;
      mode = 3'(m);
      run_in = 1;
      enable_in = 1;
      exp_q = '{4'h1, 4'h2, 4'h3};
      cyc(5);
      chk(cmd, {1'b1, step_dir[1:0], panel_freq});
      for (int k = 0; k < 99 && step_out !== 4'h3; k++) cyc(1);
      run_in = 0;
      cyc(4);
      chk(cmd, 0);
      run_in = 1;
      for (int s = (m > 3) ? 0 : 4; s < 16; s++) exp_q.push_back(4'(s));
      if (m % 3 == 2) exp_q = {exp_q, 4'h0, 4'h1};
      for (int k = 0; k < 900 && exp_q.size() > 0; k++) cyc(1);
      chk(exp_q.size(), 0);
      if (m % 3 != 2) begin
        for (int k = 0; k < 40 && done !== 1'b1; k++) cyc(1);
        cyc(2);
        chk({done, cmd}, (m % 3) ? 20'hc0000
                                 : {2'b11, step_dir[31:30], step_freq[255:240]});
      end
      enable_in = 0;
      cyc(7);
      chk(cmd, 0);
      run_in = 0;
      mode = 3'h0;
      cyc(3);
      $display("test mode %0d done", m);
    end
    // out-of-range settings clamp, reset in mid-run, mode 7 counts as off
    panel_freq = 16'hffff;
    step_dir[1:0] = 2'h3;
    step_time[11:0] = 12'hfff;
    mode = 3'h4;
    run_in = 1;
    enable_in = 1;
    cyc(5);
    chk(cmd, {1'b1, DIR_STOP, FREQ_MAX});
    rstn = 0;
    cyc(1);
    chk({done, step_out, cmd}, 0);
    rstn = 1;
    mode = 3'h7;
    cyc(6);
    chk({done, cmd}, 0);
    {run_in, enable_in, mode} = '0;
    cyc(3);
    $display("test clamp done");
    report_and_stop;
  end
endmodule
